/* File: spm_pin_mux.sv */
// shared pad multiplexer: gpio, straps, interrupts, timers, tdm, ethernet
// What this block does
// RULE1: each muxed pad carries exactly one function, chosen per pad by register.
// RULE2: 32 gpio pads, with two dedicated inputs and two dedicated outputs.
// RULE3: identity straps captured when power-on reset rises, then held.
// RULE4: each counter pad is input to or output from its counter, by config.
// RULE5: fifteen active-low request lines are routed on to the interrupt controller.
// RULE6: port 3 transmit-data pad may output lane D instead of serial data.
// RULE7: receive-data pad may input lane A, receive sync pad lane B.
// RULE8: receive-clock pad may carry lane C instead of the receive clock.
// RULE9: transmit clock comes from the far device; frame syncs are two-way.
// RULE10: RMII uses data bits 0 and 1 only; MII uses bits 0 to 3.
// RULE11: transmit-error output is driven in MII mode only.
// RULE12: collision input is meaningful in MII mode only.
// RULE13: MII uses receive-valid; RMII uses combined carrier-or-valid instead.
// RULE14: management data line is two-way in MII, RMII and SMII.
// RULE15: pad unused in SMII is left open by the board and ignored.
// RULE16: after reset every pad is a non-driving gpio input.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module spm_pin_mux import spm_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pads
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe,
  input wire logic power_on_reset_n,
  input wire logic [IRQ_LINES-PAD_IRQ_LINES-1:0] ext_irq_n_hi,
  // interrupt controller and identity
  output logic [IRQ_LINES-1:0] irq_req_n,
  output logic irq_out,
  output logic [2:0] chip_id,
  // dedicated gpio ports
  input wire logic [DED_PORTS-1:0] ded_out_val,
  output logic [DED_PORTS-1:0] ded_in_val,
  // counters
  input wire logic [1:0] counter_pin_drive,
  output logic [1:0] counter_pin_sense,
  // tdm port 3
  input wire logic port3_tx_frame_sync_drive,
  input wire logic port3_tx_frame_sync_en,
  output logic port3_tx_frame_sync,
  output logic port3_tx_serial_clock,
  input wire logic port3_tx_serial_data,
  input wire logic port3_lane_d,
  input wire logic port3_rx_frame_sync_drive,
  input wire logic port3_rx_frame_sync_en,
  output logic port3_rx_frame_sync,
  output logic port3_rx_serial_clock,
  output logic port3_rx_serial_data,
  output logic port3_lane_a,
  output logic port3_lane_b,
  output logic port3_lane_c,
  // tdm port 2
  input wire logic port2_tx_frame_sync_drive,
  input wire logic port2_tx_frame_sync_en,
  output logic port2_tx_frame_sync,
  output logic port2_tx_serial_clock,
  // ethernet mac
  input wire logic [3:0] mac_tx_data,
  input wire logic mac_tx_error,
  output logic mac_rx_bit2,
  output logic mac_rx_bit3,
  output logic mac_collision,
  output logic mac_rx_valid,
  output logic mac_carrier_or_valid,
  input wire logic mac_mgmt_data_drive,
  input wire logic mac_mgmt_data_en,
  output logic mac_mgmt_data
);

  // ********
  // helpers
  // ********
  // pads past the muxed group are plain gpio
  function automatic spm_fn_e pad_fn(input logic [31:0] sel, input int p);
    if (p >= MUX_PADS) return FN_GPIO;
    return spm_fn_e'(sel[2*p +: 2]);
  endfunction : pad_fn

  function automatic logic [31:0] merge_be(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : merge_be

  function automatic logic addr_hit(input logic [7:0] a);
    return (a == ADDR_FUNC) || (a == ADDR_DIR) || (a == ADDR_OUT) ||
           (a == ADDR_IN) || (a == ADDR_CFG) || (a == ADDR_STRAP) ||
           (a == ADDR_STAT) || (a == ADDR_MASK) || (a == ADDR_DED);
  endfunction : addr_hit

  // ********
  // synchronised pins
  // ********
  logic [NUM_PADS-1:0] pad_s;
  logic por_s;
  logic [IRQ_LINES-PAD_IRQ_LINES-1:0] irq_hi_s;

  spm_sync #(.WIDTH(NUM_PADS), .RST_VAL('0)) u_pad_sync (
    .aclk(aclk), .aresetn(aresetn), .async_in(pad_in), .sync_out(pad_s)
  );
  // idles high so a reset with the pin already up makes no false capture
  spm_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_por_sync (
    .aclk(aclk), .aresetn(aresetn), .async_in(power_on_reset_n), .sync_out(por_s)
  );
  spm_sync #(.WIDTH(IRQ_LINES-PAD_IRQ_LINES), .RST_VAL('1)) u_irq_sync (
    .aclk(aclk), .aresetn(aresetn), .async_in(ext_irq_n_hi), .sync_out(irq_hi_s)
  );

  // ********
  // register file
  // ********
  logic [31:0] func_sel, gpio_dir, gpio_out, cfg, irq_mask, ded_cfg;
  logic [IRQ_LINES-1:0] irq_stat;
  logic wr_take, rd_take;
  logic [31:0] wval, next_rdata;
  spm_fn_e fn [MUX_PADS];
  spm_eth_e eth_mode;
  logic mii, mii_rmii;

  assign wr_take = awready && awvalid && wvalid;
  assign rd_take = arready && arvalid;
  assign eth_mode = spm_eth_e'(cfg[CFG_ETH_LSB +: 2]);
  assign mii = (eth_mode == ETH_MII);
  assign mii_rmii = mii || (eth_mode == ETH_RMII); // see RULE10

  // per-pad function decode, one selection per pad
  genvar g;
  generate
    for (g = 0; g < MUX_PADS; g++) begin : g_fn
      assign fn[g] = pad_fn(func_sel, g); // see RULE1
    end
  endgenerate

  // control registers; all start as gpio inputs with nothing driven
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_sel <= FUNC_RST; // see RULE16
      gpio_dir <= DIR_RST; // see RULE16
      gpio_out <= OUT_RST;
      cfg <= CFG_RST;
      irq_mask <= MASK_RST;
      ded_cfg <= DED_RST;
    end else if (wr_take) begin
      case (awaddr)
        ADDR_FUNC: func_sel <= {10'h000, wval[2*MUX_PADS-1:0]};
        ADDR_DIR: gpio_dir <= wval;
        ADDR_OUT: gpio_out <= wval;
        ADDR_CFG: cfg <= {24'h00_0000, wval[7:0]};
        ADDR_MASK: irq_mask <= {17'h0_0000, wval[IRQ_LINES-1:0]};
        ADDR_DED: ded_cfg <= wval & 32'h9F9F_9F9F;
        default: ;
      endcase
    end
  end

  // merged write value of the addressed register
  always_comb begin
    case (awaddr)
      ADDR_FUNC: wval = merge_be(func_sel, wdata, wstrb);
      ADDR_DIR: wval = merge_be(gpio_dir, wdata, wstrb);
      ADDR_OUT: wval = merge_be(gpio_out, wdata, wstrb);
      ADDR_CFG: wval = merge_be(cfg, wdata, wstrb);
      ADDR_MASK: wval = merge_be(irq_mask, wdata, wstrb);
      ADDR_DED: wval = merge_be(ded_cfg, wdata, wstrb);
      ADDR_STAT: wval = wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      default: wval = 32'h0000_0000;
    endcase
  end

  // read mux; reserved bits read zero
  always_comb begin
    case (araddr)
      ADDR_FUNC: next_rdata = func_sel;
      ADDR_DIR: next_rdata = gpio_dir;
      ADDR_OUT: next_rdata = gpio_out;
      ADDR_IN: next_rdata = pad_s;
      ADDR_CFG: next_rdata = cfg;
      ADDR_STRAP: next_rdata = {29'h0000_0000, chip_id};
      ADDR_STAT: next_rdata = {17'h0_0000, irq_stat};
      ADDR_MASK: next_rdata = irq_mask;
      ADDR_DED: next_rdata = ded_cfg;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ********
  // axi4-lite handshakes
  // ********
  // address and data are taken together, one write outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= addr_hit(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // reads answer one edge after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ********
  // identity straps
  // ********
  logic por_prev;

  // sampled on the release edge only, so later pad traffic cannot disturb it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_prev <= 1'b1;
      chip_id <= STRAP_RST;
    end else begin
      por_prev <= por_s;
      if (por_s && !por_prev) chip_id <= pad_s[2:0]; // see RULE3
    end
  end

  // ********
  // pad drive
  // ********
  logic [NUM_PADS-1:0] next_pad_out, next_pad_oe;

  always_comb begin
    next_pad_out = gpio_out;
    next_pad_oe = gpio_dir;
    for (int i = 0; i < MUX_PADS; i++) begin
      if (fn[i] != FN_GPIO) begin
        next_pad_out[i] = 1'b0;
        next_pad_oe[i] = 1'b0;
      end
    end
    // dedicated outputs only claim pads left in gpio function
    for (int k = 0; k < DED_PORTS; k++) begin
      if (ded_cfg[DED_OUT_LSB + DED_STRIDE*k + DED_EN_BIT] &&
          pad_fn(func_sel, int'(ded_cfg[DED_OUT_LSB + DED_STRIDE*k +: DED_PAD_W])) == FN_GPIO) begin
        next_pad_out[ded_cfg[DED_OUT_LSB + DED_STRIDE*k +: DED_PAD_W]] = ded_out_val[k]; // see RULE2
        next_pad_oe[ded_cfg[DED_OUT_LSB + DED_STRIDE*k +: DED_PAD_W]] = 1'b1;
      end
    end
    // counter pads drive only when set as outputs
    if (fn[1] == FN_ALT) begin
      next_pad_out[1] = counter_pin_drive[0];
      next_pad_oe[1] = cfg[CFG_TMR0_OUT]; // see RULE4
    end
    if (fn[2] == FN_ALT) begin
      next_pad_out[2] = counter_pin_drive[1];
      next_pad_oe[2] = cfg[CFG_TMR1_OUT]; // see RULE4
    end
    // frame syncs follow the port's own enable
    if (fn[3] == FN_ALT) begin
      next_pad_out[3] = port3_tx_frame_sync_drive;
      next_pad_oe[3] = port3_tx_frame_sync_en; // see RULE9
    end
    if (fn[5] == FN_ALT) begin
      next_pad_out[5] = cfg[CFG_LANE_D] ? port3_lane_d : port3_tx_serial_data; // see RULE6
      next_pad_oe[5] = 1'b1;
    end
    if (fn[6] == FN_ALT && !cfg[CFG_LANE_B]) begin
      next_pad_out[6] = port3_rx_frame_sync_drive;
      next_pad_oe[6] = port3_rx_frame_sync_en; // see RULE9
    end
    if (fn[9] == FN_ALT) begin
      next_pad_out[9] = port2_tx_frame_sync_drive;
      next_pad_oe[9] = port2_tx_frame_sync_en; // see RULE9
    end
    // ethernet transmit side; wide bits and error only in mii
    if (fn[0] == FN_ETH && mii_rmii) begin
      next_pad_out[0] = mac_tx_data[0]; // see RULE10
      next_pad_oe[0] = 1'b1;
    end
    if (fn[1] == FN_ETH && mii_rmii) begin
      next_pad_out[1] = mac_tx_data[1]; // see RULE10
      next_pad_oe[1] = 1'b1;
    end
    if (fn[3] == FN_ETH && mii) begin
      next_pad_out[3] = mac_tx_data[2]; // see RULE10
      next_pad_oe[3] = 1'b1;
    end
    if (fn[4] == FN_ETH && mii) begin
      next_pad_out[4] = mac_tx_error; // see RULE11
      next_pad_oe[4] = 1'b1;
    end
    if (fn[7] == FN_ETH && mii) begin
      next_pad_out[7] = mac_tx_data[3]; // see RULE10
      next_pad_oe[7] = 1'b1;
    end
    if (fn[9] == FN_ETH && eth_mode != ETH_OFF) begin
      next_pad_out[9] = mac_mgmt_data_drive; // see RULE14
      next_pad_oe[9] = mac_mgmt_data_en;
    end
  end

  // pad outputs registered so nothing glitches onto the board
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out <= '0;
      pad_oe <= '0; // see RULE16
    end else begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
    end
  end

  // ********
  // inputs to the peripherals
  // ********
  // unselected inputs read as idle so peripherals see no stray edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_pin_sense <= 2'h0;
      port3_tx_frame_sync <= 1'b0;
      port3_tx_serial_clock <= 1'b0;
      port3_rx_frame_sync <= 1'b0;
      port3_rx_serial_clock <= 1'b0;
      port3_rx_serial_data <= 1'b0;
      port3_lane_a <= 1'b0;
      port3_lane_b <= 1'b0;
      port3_lane_c <= 1'b0;
      port2_tx_frame_sync <= 1'b0;
      port2_tx_serial_clock <= 1'b0;
      ded_in_val <= '0;
    end else begin
      counter_pin_sense[0] <= (fn[1] == FN_ALT) && !cfg[CFG_TMR0_OUT] && pad_s[1]; // see RULE4
      counter_pin_sense[1] <= (fn[2] == FN_ALT) && !cfg[CFG_TMR1_OUT] && pad_s[2]; // see RULE4
      port3_tx_frame_sync <= (fn[3] == FN_ALT) && pad_s[3];
      port3_tx_serial_clock <= (fn[4] == FN_ALT) && pad_s[4]; // see RULE9
      port3_rx_frame_sync <= (fn[6] == FN_ALT) && !cfg[CFG_LANE_B] && pad_s[6];
      port3_lane_b <= (fn[6] == FN_ALT) && cfg[CFG_LANE_B] && pad_s[6]; // see RULE7
      port3_rx_serial_clock <= (fn[7] == FN_ALT) && !cfg[CFG_LANE_C] && pad_s[7];
      port3_lane_c <= (fn[7] == FN_ALT) && cfg[CFG_LANE_C] && pad_s[7]; // see RULE8
      port3_rx_serial_data <= (fn[8] == FN_ALT) && !cfg[CFG_LANE_A] && pad_s[8];
      port3_lane_a <= (fn[8] == FN_ALT) && cfg[CFG_LANE_A] && pad_s[8]; // see RULE7
      port2_tx_frame_sync <= (fn[9] == FN_ALT) && pad_s[9];
      port2_tx_serial_clock <= (fn[10] == FN_ALT) && pad_s[10]; // see RULE9
      for (int k = 0; k < DED_PORTS; k++) begin
        ded_in_val[k] <= ded_cfg[DED_IN_LSB + DED_STRIDE*k + DED_EN_BIT] &&
                         pad_s[ded_cfg[DED_IN_LSB + DED_STRIDE*k +: DED_PAD_W]]; // see RULE2
      end
    end
  end

  // ethernet receive side gated by mode; smii leaves pad 10 ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_rx_bit3 <= 1'b0;
      mac_rx_bit2 <= 1'b0;
      mac_collision <= 1'b0;
      mac_rx_valid <= 1'b0;
      mac_carrier_or_valid <= 1'b0;
      mac_mgmt_data <= 1'b0;
    end else begin
      mac_rx_bit3 <= (fn[5] == FN_ETH) && mii && pad_s[5]; // see RULE10
      mac_rx_bit2 <= (fn[6] == FN_ETH) && mii && pad_s[6]; // see RULE10
      mac_collision <= (fn[8] == FN_ETH) && mii && pad_s[8]; // see RULE12
      mac_rx_valid <= (fn[10] == FN_ETH) && mii && pad_s[10]; // see RULE13
      mac_carrier_or_valid <= (fn[10] == FN_ETH) && (eth_mode == ETH_RMII) &&
                              pad_s[10]; // see RULE13 RULE15
      mac_mgmt_data <= (fn[9] == FN_ETH) && (eth_mode != ETH_OFF) && pad_s[9]; // see RULE14
    end
  end

  // ********
  // interrupt requests
  // ********
  logic [IRQ_LINES-1:0] next_irq_n, irq_prev_n, irq_fall, irq_clr;

  // a line shared by two pads is low if either selected pad is low
  always_comb begin
    next_irq_n = {irq_hi_s, {PAD_IRQ_LINES{1'b1}}};
    for (int i = 0; i < MUX_PADS; i++) begin
      if (fn[i] == FN_IRQ) next_irq_n[PAD_IRQ_NUM[i] - 4'h1] &= pad_s[i]; // see RULE5
    end
  end

  assign irq_fall = irq_prev_n & ~irq_req_n;
  assign irq_clr = (wr_take && awaddr == ADDR_STAT) ? wval[IRQ_LINES-1:0] : '0;

  // sticky on the falling edge; a new edge beats a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req_n <= '1;
      irq_prev_n <= '1;
      irq_stat <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_req_n <= next_irq_n; // see RULE5
      irq_prev_n <= irq_req_n;
      irq_stat <= (irq_stat & ~irq_clr) | irq_fall;
      irq_out <= |(irq_stat & irq_mask[IRQ_LINES-1:0]);
    end
  end

endmodule : spm_pin_mux
`default_nettype wire

/* File: spm_pkg.sv */
// constants, field layout and types shared by the shared pin multiplexer
package spm_pkg;

  // ********
  // pad counts
  // ********
  localparam int NUM_PADS = 32;
  localparam int MUX_PADS = 11;
  localparam int IRQ_LINES = 15;
  localparam int PAD_IRQ_LINES = 8;
  localparam int DED_PORTS = 2;

  // ********
  // register byte offsets
  // ********
  localparam logic [7:0] ADDR_FUNC = 8'h00;
  localparam logic [7:0] ADDR_DIR = 8'h04;
  localparam logic [7:0] ADDR_OUT = 8'h08;
  localparam logic [7:0] ADDR_IN = 8'h0C;
  localparam logic [7:0] ADDR_CFG = 8'h10;
  localparam logic [7:0] ADDR_STRAP = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;
  localparam logic [7:0] ADDR_DED = 8'h20;

  // ********
  // reset values: every pad a non-driving gpio input
  // ********
  localparam logic [31:0] FUNC_RST = 32'h0000_0000;
  localparam logic [31:0] DIR_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] DED_RST = 32'h0000_0000;
  localparam logic [2:0] STRAP_RST = 3'h0;

  // ********
  // config register fields
  // ********
  localparam int CFG_ETH_LSB = 0;
  localparam int CFG_TMR0_OUT = 2;
  localparam int CFG_TMR1_OUT = 3;
  localparam int CFG_LANE_D = 4;
  localparam int CFG_LANE_A = 5;
  localparam int CFG_LANE_B = 6;
  localparam int CFG_LANE_C = 7;

  // dedicated port fields: pad index in low bits, enable on top bit
  localparam int DED_PAD_W = 5;
  localparam int DED_IN_LSB = 0;
  localparam int DED_OUT_LSB = 16;
  localparam int DED_STRIDE = 8;
  localparam int DED_EN_BIT = 7;

  // ********
  // line number (1..8) of the request carried by each muxed pad
  // ********
  localparam logic [3:0] PAD_IRQ_NUM [0:MUX_PADS-1] = '{
    4'h4, 4'h5, 4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8
  };

  // ********
  // bus answers and types
  // ********
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FN_GPIO = 2'b00,
    FN_ALT = 2'b01,
    FN_IRQ = 2'b10,
    FN_ETH = 2'b11
  } spm_fn_e;

  typedef enum logic [1:0] {
    ETH_MII = 2'b00,
    ETH_RMII = 2'b01,
    ETH_SMII = 2'b10,
    ETH_OFF = 2'b11
  } spm_eth_e;

endpackage : spm_pkg

/* File: spm_sync.sv */
// two flip-flop synchroniser for levels entering from pins
`timescale 1ns/1ps
`default_nettype none

module spm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second, never any logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : spm_sync
`default_nettype wire

/* File: spm_pin_mux_props.sv */
// port checker for the shared pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux_props import spm_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // pads, requests, identity
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic power_on_reset_n,
  input wire logic [IRQ_LINES-1:0] irq_req_n,
  input wire logic irq_out,
  input wire logic [2:0] chip_id
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // edges since the power-on pin rose; identity may move only just after
  logic [2:0] por_age;
  always_ff @(posedge aclk) begin
    if (!aresetn) por_age <= 3'h7;
    else if ($rose(power_on_reset_n)) por_age <= 3'h0;
    else if (por_age != 3'h7) por_age <= por_age + 3'h1;
  end
  property p_rst_quiet; $rose(aresetn) |-> !pad_oe && &irq_req_n && !irq_out && !bvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
  property p_aw_take; awvalid && wvalid && !awready && !bvalid |=> awready && wready;
  endproperty
  a_aw_take: assert property (p_aw_take) else $error("write not taken");
  property p_b_answer; awready |=> bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  property p_b_hold; bvalid && !bready |=> bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_ar_take; arvalid && !arready && !rvalid |=> arready;
  endproperty
  a_ar_take: assert property (p_ar_take) else $error("read not taken");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer moved");
  property p_rd_err; arready && araddr > ADDR_DED |=> rvalid && rresp == RESP_SLVERR;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read okay");
  property p_chip_hold; $changed(chip_id) && $past(aresetn) |-> por_age < 3'h6;
  endproperty
  a_chip_hold: assert property (p_chip_hold) else $error("identity moved");
endmodule : spm_pin_mux_props
bind spm_pin_mux spm_pin_mux_props i_spm_pin_mux_props (.*);
`default_nettype wire

/* File: spm_pad_model.sv */
// far-side pad model: external drivers and resolved pad level
`timescale 1ns/1ps
`default_nettype none
module spm_pad_model import spm_pkg::*; (
  // design drive and far-side levels
  input wire logic [NUM_PADS-1:0] pad_out,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] ext_lvl,
  // level seen by the design
  output logic [NUM_PADS-1:0] pad_in
);
  // ********
  // pad resolution
  // ********
  // far side backs off where the design drives, so no contention
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : spm_pad_model
`default_nettype wire

/* File: spm_pin_mux_bench.sv */
// self-checking bench for the shared pin multiplexer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module spm_pin_mux_bench import spm_pkg::*;;
  // ********
  // stimulus and checks
  // ********
  int seed = 32'h8248, err_total = 0, tests_run = 0;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, power_on_reset_n = 1'b0, port3_lane_d = 1'b0;
  logic port3_tx_serial_data = 1'b0, mac_tx_error = 1'b0, mac_mgmt_data_drive = 1'b0;
  logic mac_mgmt_data_en = 1'b0, awready, wready, bvalid, arready, rvalid, irq_out;
  logic port3_lane_a, port3_lane_b, port3_lane_c, mac_rx_bit3, mac_collision;
  logic mac_rx_valid, mac_carrier_or_valid, mac_rx_bit2;
  logic [1:0] ded_out_val = 2'h0, counter_pin_drive = 2'h0, ded_in_val, counter_pin_sense;
  logic [1:0] rresp, bresp;
  logic [2:0] chip_id;
  logic [3:0] wstrb = 4'hF, mac_tx_data = 4'h0;
  logic [5:0] fsync = 6'h0;
  logic [6:0] ext_irq_n_hi = 7'h7F;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [14:0] irq_req_n;
  logic [31:0] wdata = 32'h0, ext_lvl = 32'h0, pad_in, pad_out, pad_oe, rdata, gdir, gout;
  always #5 aclk = ~aclk;
  spm_pin_mux i_spm_pin_mux (.*, .port3_tx_frame_sync_drive(fsync[0]),
    .port3_tx_frame_sync_en(fsync[1]), .port3_rx_frame_sync_drive(fsync[2]),
    .port3_rx_frame_sync_en(fsync[3]), .port2_tx_frame_sync_drive(fsync[4]),
    .port2_tx_frame_sync_en(fsync[5]), .port3_tx_frame_sync(), .port3_tx_serial_clock(),
    .port3_rx_frame_sync(), .port3_rx_serial_clock(), .port3_rx_serial_data(),
    .port2_tx_frame_sync(), .port2_tx_serial_clock(), .mac_mgmt_data());
  spm_pad_model i_spm_pad_model (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl),
    .pad_in(pad_in));
  // bus write; a random stall before bready exercises the held answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", RESP_OKAY, bresp)
  endtask : wr
  // bus read with comparison of data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", r, rresp)
  endtask : rd
  // pad changes need the synchroniser plus the output register
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask : settle
  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    ext_lvl <= 32'h0000_0005;
    settle();
    power_on_reset_n <= 1'b1;
    settle();
    `CHK("chip_id", 3'h5, chip_id)
    rd(ADDR_STRAP, 32'h0000_0005, RESP_OKAY);
    rd(ADDR_FUNC, FUNC_RST, RESP_OKAY);
    rd(ADDR_CFG, CFG_RST, RESP_OKAY);
    `CHK("pad_oe", 32'h0, pad_oe)
    rd(8'h40, 32'h0, RESP_SLVERR);
    // plain gpio with random direction, drive and far-side levels
    for (int i = 0; i < 6; i++) begin
      gdir = $random(seed);
      gout = $random(seed);
      ext_lvl <= $random(seed);
      fsync <= 6'($random(seed));
      wr(ADDR_DIR, gdir);
      wr(ADDR_OUT, gout);
      settle();
      `CHK("pad_oe", gdir, pad_oe)
      `CHK("pad_out", gout & gdir, pad_out & gdir)
      rd(ADDR_IN, (gdir & gout) | (~gdir & ext_lvl), RESP_OKAY);
    end
    // dedicated input on pad 20, dedicated output on pad 21
    wr(ADDR_DIR, 32'h0);
    wr(ADDR_DED, 32'h0095_0094);
    ded_out_val <= 2'h1;
    ext_lvl <= 32'h0010_0000;
    settle();
    `CHK("ded_out", 2'h3, {pad_oe[21], pad_out[21]})
    `CHK("ded_in", 2'h1, ded_in_val)
    // counter 0 drives pad 1, counter 1 senses pad 2, lanes on pads 5 to 8
    wr(ADDR_FUNC, 32'h0001_5414);
    wr(ADDR_CFG, 32'h0000_00F4);
    counter_pin_drive <= 2'h1;
    port3_lane_d <= 1'b1;
    ext_lvl <= 32'h0000_01C4;
    settle();
    `CHK("ctr0", 2'h3, {pad_oe[1], pad_out[1]})
    `CHK("ctr1", 2'h2, counter_pin_sense)
    `CHK("lane_d", 1'b1, pad_out[5])
    `CHK("lane_ab", 2'h3, {port3_lane_a, port3_lane_b})
    `CHK("lane_c", 1'b1, port3_lane_c)
    // request line 1 on pad 3 and line 9, masked then unmasked
    ext_lvl <= 32'h0000_0008;
    wr(ADDR_FUNC, 32'h0000_0080);
    settle();
    wr(ADDR_STAT, 32'h0000_7FFF);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_MASK, m ? 32'h0000_0101 : 32'h0);
      ext_lvl <= 32'h0;
      ext_irq_n_hi <= 7'h7E;
      settle();
      `CHK("irq_n", 15'h7EFE, irq_req_n)
      `CHK("irq_out", m[0], irq_out)
      rd(ADDR_STAT, 32'h0000_0101, RESP_OKAY);
      ext_lvl <= 32'h0000_0008;
      ext_irq_n_hi <= 7'h7F;
      wr(ADDR_STAT, 32'h0000_0101);
      settle();
      `CHK("irq_clr", 1'b0, irq_out)
    end
    // ethernet pads through every mode
    wr(ADDR_FUNC, 32'h003F_FFFF);
    mac_tx_data <= 4'hF;
    mac_tx_error <= 1'b1;
    mac_mgmt_data_en <= 1'b1;
    ext_lvl <= 32'h0000_0560;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CFG, 32'(k));
      settle();
      `CHK("tx_lo", k < 2, pad_oe[0])
      `CHK("tx_hi", {2{k == 0}}, {pad_oe[3], pad_oe[7]})
      `CHK("tx_err", k == 0, pad_oe[4])
      `CHK("mgmt", k != 3, pad_oe[9])
      `CHK("rx_mii", {4{k == 0}}, {mac_rx_bit3, mac_rx_bit2, mac_collision, mac_rx_valid})
      `CHK("rx_rmii", k == 1, mac_carrier_or_valid)
    end
    `CHK("chip_hold", 3'h5, chip_id)
    give_verdict();
  end
endmodule : spm_pin_mux_bench
`default_nettype wire
